// File: hw/pidl_core.sv
// Three-term control law with register port, current-loop and
// time-proportioned heating and cooling outputs.
// Assumes MEAS_VALID pulses with a settled MEAS_VALUE, all synchronous.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "pidl_defs.svh"
module pidl_core #(
    parameter logic [63:0] MINUTE_CYCLES = `PIDL_MINUTE_NS / `PIDL_CLK_NS
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire pidl_pkg::pidl_req_t BUS_REQ,
    output logic [31:0] RD_DATA,
    input wire logic [15:0] MEAS_VALUE,
    input wire logic MEAS_VALID,
    output pidl_pkg::pidl_drive_t DRIVE,
    output logic [15:0] HEAT_LOOP_UA,
    output logic [15:0] COOL_LOOP_UA,
    output logic HEAT_ON,
    output logic COOL_ON
);
    import pidl_pkg::*;
    // One clock domain; reset masks every check
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // Configuration registers
    logic signed [15:0] target_q, target_d;
    logic [7:0] gain_q, gain_d;
    logic [7:0] repeat_q, repeat_d;
    logic [7:0] windup_q, windup_d;
    logic signed [15:0] splo_q, splo_d, sphi_q, sphi_d;
    logic [7:0] deriv_q, deriv_d;
    logic [15:0] slot_q, slot_d;
    pidl_mode_t mode_q, mode_d;
    logic [31:0] rd_q, rd_d;

    // Control state
    pidl_state_t st_q, st_d;
    logic signed [15:0] pv_q, pv_d, pvold_q, pvold_d;
    logic signed [15:0] corr_q, corr_d;
    logic [47:0] racc_q, racc_d;
    logic [15:0] tick_q, tick_d;
    logic [7:0] slot_idx_q, slot_idx_d;
    pidl_drive_t drv_q, drv_d;
    logic [15:0] hua_q, hua_d, cua_q, cua_d;
    logic hon_q, hon_d, con_q, con_d;

    logic signed [15:0] intsp_w;
    logic signed [17:0] span, dev, adj, mag, lim, clip;
    logic signed [41:0] pnum, ppct, dpct, tot;
    logic rep_evt, in_band;
    logic [47:0] racc_sum, minute_h;

    always_comb begin
        target_d = target_q;
        gain_d = gain_q;
        repeat_d = repeat_q;
        windup_d = windup_q;
        splo_d = splo_q;
        sphi_d = sphi_q;
        deriv_d = deriv_q;
        slot_d = slot_q;
        mode_d = mode_q;
        rd_d = 32'h0000_0000;
        if (BUS_REQ.wr) begin
            case (BUS_REQ.addr)
                `PIDL_A_TARGET: target_d = BUS_REQ.wdata[15:0];
                `PIDL_A_GAIN: gain_d = BUS_REQ.wdata[7:0];
                `PIDL_A_REPEAT: repeat_d = BUS_REQ.wdata[7:0];
                `PIDL_A_WINDUP: windup_d = BUS_REQ.wdata[7:0];
                `PIDL_A_SPLO: splo_d = BUS_REQ.wdata[15:0];
                `PIDL_A_SPHI: sphi_d = BUS_REQ.wdata[15:0];
                `PIDL_A_DERIV: deriv_d = BUS_REQ.wdata[7:0];
                `PIDL_A_SLOT: slot_d = BUS_REQ.wdata[15:0];
                `PIDL_A_MODE: mode_d = pidl_mode_t'(BUS_REQ.wdata[0]);
                default: ;
            endcase
        end
        if (BUS_REQ.rd) begin
            case (BUS_REQ.addr)
                `PIDL_A_TARGET: rd_d = {16'h0000, target_q};
                `PIDL_A_GAIN: rd_d = {24'h00_0000, gain_q};
                `PIDL_A_REPEAT: rd_d = {24'h00_0000, repeat_q};
                `PIDL_A_WINDUP: rd_d = {24'h00_0000, windup_q};
                `PIDL_A_SPLO: rd_d = {16'h0000, splo_q};
                `PIDL_A_SPHI: rd_d = {16'h0000, sphi_q};
                `PIDL_A_DERIV: rd_d = {24'h00_0000, deriv_q};
                `PIDL_A_SLOT: rd_d = {16'h0000, slot_q};
                `PIDL_A_MODE: rd_d = {31'h0000_0000, mode_q};
                `PIDL_A_STAT: rd_d = {16'h0000, DRIVE};
                `PIDL_A_INTSP: rd_d = {16'h0000, intsp_w};
                `PIDL_A_MEAS: rd_d = {16'h0000, pv_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            target_q <= 16'h0000;
            gain_q <= `PIDL_R_GAIN;
            repeat_q <= `PIDL_R_REPEAT;
            windup_q <= `PIDL_R_WINDUP;
            splo_q <= `PIDL_R_SPLO;
            sphi_q <= `PIDL_R_SPHI;
            deriv_q <= 8'h00;
            slot_q <= `PIDL_R_SLOT;
            mode_q <= PIDL_CURRENT;
            rd_q <= 32'h0000_0000;
        end else if (CE) begin
            target_d_apply: begin
                target_q <= target_d;
                gain_q <= gain_d;
                repeat_q <= repeat_d;
                windup_q <= windup_d;
                splo_q <= splo_d;
                sphi_q <= sphi_d;
                deriv_q <= deriv_d;
                slot_q <= slot_d;
                mode_q <= mode_d;
                rd_q <= rd_d;
            end
        end
    end
    assign RD_DATA = rd_q;

    // Wide terms only; the division is the costly path, kept combinational
    // because the loop runs far slower than the clock.
    always_comb begin
        span = 18'(sphi_q) - 18'(splo_q); // [R4]
        dev = 18'(target_q) - 18'(pv_q); // [R1]
        intsp_w = target_q + corr_q; // [R10]
        adj = 18'(intsp_w) - 18'(pv_q); // [R11]
        mag = dev[17] ? -dev : dev;
        // |dev| <= span/gain, cross-multiplied to avoid a divider [R3] [R14]
        in_band = (gain_q != 8'h00) &&
            (42'(mag) * 42'(gain_q) <= 42'(span));
        if (windup_q == 8'h00 || windup_q > `PIDL_PCT_FULL) begin
            lim = 18'(42'(span) / 42'(gain_q == 8'h00 ? 8'h01 : gain_q));
        end else begin
            lim = 18'((42'(span) * 42'(windup_q)) /
                (42'(gain_q == 8'h00 ? 8'h01 : gain_q) *
                42'(`PIDL_PCT_FULL))); // [R15]
        end
        clip = dev > lim ? lim : (dev < -lim ? -lim : dev); // [R15]
        minute_h = MINUTE_CYCLES[47:0] * `PIDL_HUND; // [R17]
        racc_sum = racc_q + 48'(repeat_q); // [R12] [R17]
        rep_evt = racc_sum >= minute_h;
        pnum = 42'(adj) * 42'(`PIDL_PCT_FULL) * 42'(gain_q);
        if (gain_q == 8'h00) begin
            // Zero band behaves as a plain on/off thermostat
            ppct = adj > 0 ? 42'(`PIDL_PCT_FULL) :
                (adj < 0 ? -42'(`PIDL_PCT_FULL) : 42'h0);
        end else begin
            ppct = pnum / 42'(span); // [R2] [R3]
        end
        dpct = 42'(pvold_q - pv_q) * 42'(deriv_q); // [R16]
        tot = ppct + dpct; // [R8]
    end

    always_comb begin
        st_d = st_q;
        pv_d = pv_q;
        pvold_d = pvold_q;
        corr_d = corr_q;
        racc_d = rep_evt ? racc_sum - minute_h : racc_sum;
        tick_d = tick_q;
        slot_idx_d = slot_idx_q;
        drv_d = drv_q;
        hua_d = hua_q;
        cua_d = cua_q;
        hon_d = hon_q;
        con_d = con_q;
        case (st_q)
            PIDL_WAIT: begin
                if (MEAS_VALID) begin
                    pvold_d = pv_q;
                    pv_d = MEAS_VALUE;
                    st_d = PIDL_LATCH;
                end
            end
            PIDL_LATCH: st_d = PIDL_WAIT;
            default: st_d = PIDL_WAIT;
        endcase
        if (rep_evt && in_band) begin
            corr_d = corr_q + clip[15:0]; // [R9] [R12] [R13] [R14]
        end
        // Heat takes positive demand, cool the negative side [R7] [R18]
        // Signed bounds: unsigned ones would read negative demand as full
        drv_d.heat_pct = tot > $signed(42'(`PIDL_PCT_FULL)) ? `PIDL_PCT_FULL :
            (tot < 0 ? 8'h00 : tot[7:0]);
        drv_d.cool_pct = tot < -$signed(42'(`PIDL_PCT_FULL)) ? `PIDL_PCT_FULL :
            (tot > 0 ? 8'h00 : 8'(-tot));
        hua_d = `PIDL_MA4 + 16'(drv_q.heat_pct) * `PIDL_UA_PER_PCT; // [R5]
        cua_d = `PIDL_MA4 + 16'(drv_q.cool_pct) * `PIDL_UA_PER_PCT; // [R5]
        if (tick_q + 16'h0001 >= slot_q) begin
            tick_d = 16'h0000;
            slot_idx_d = slot_idx_q + 8'h01 >= `PIDL_PCT_FULL ?
                8'h00 : slot_idx_q + 8'h01;
        end else begin
            tick_d = tick_q + 16'h0001;
        end
        // Current mode leaves the switched outputs idle
        hon_d = mode_q == PIDL_TIMEPROP &&
            slot_idx_q < drv_q.heat_pct; // [R6]
        con_d = mode_q == PIDL_TIMEPROP &&
            slot_idx_q < drv_q.cool_pct; // [R6]
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_q <= PIDL_WAIT;
            pv_q <= 16'h0000;
            pvold_q <= 16'h0000;
            corr_q <= 16'h0000;
            racc_q <= 48'h0;
            tick_q <= 16'h0000;
            slot_idx_q <= 8'h00;
            drv_q <= '0;
            hua_q <= `PIDL_MA4;
            cua_q <= `PIDL_MA4;
            hon_q <= 1'b0;
            con_q <= 1'b0;
        end else if (CE) begin
            st_q <= st_d;
            pv_q <= pv_d;
            pvold_q <= pvold_d;
            corr_q <= corr_d;
            racc_q <= racc_d;
            tick_q <= tick_d;
            slot_idx_q <= slot_idx_d;
            drv_q <= drv_d;
            hua_q <= hua_d;
            cua_q <= cua_d;
            hon_q <= hon_d;
            con_q <= con_d;
        end
    end
    assign DRIVE = drv_q;
    assign HEAT_LOOP_UA = hua_q;
    assign COOL_LOOP_UA = cua_q;
    assign HEAT_ON = hon_q;
    assign COOL_ON = con_q;

    sequence s_step;
        CE ##1 CE;
    endsequence

    sequence s_repeat;
        CE && rep_evt && in_band;
    endsequence

    chk_pct_saturate: assert property ( // [R18]
        drv_q.heat_pct <= `PIDL_PCT_FULL && drv_q.cool_pct <= `PIDL_PCT_FULL)
        else $error("output percent above full");
    chk_heat_cool_excl: assert property ( // [R7]
        drv_q.heat_pct == 8'h00 || drv_q.cool_pct == 8'h00)
        else $error("heat and cool both active");
    chk_loop_map: assert property ( // [R5]
        CE |=> hua_q == `PIDL_MA4 +
            16'($past(drv_q.heat_pct)) * `PIDL_UA_PER_PCT)
        else $error("current loop level wrong");
    chk_cool_map: assert property ( // [R5]
        CE |=> cua_q == `PIDL_MA4 +
            16'($past(drv_q.cool_pct)) * `PIDL_UA_PER_PCT)
        else $error("cooling current loop level wrong");
    chk_tp_duty: assert property ( // [R6]
        CE |=> hon_q == ($past(mode_q) == PIDL_TIMEPROP &&
            $past(slot_idx_q) < $past(drv_q.heat_pct)))
        else $error("time-proportioned heat wrong");
    chk_cool_duty: assert property ( // [R6]
        CE |=> con_q == ($past(mode_q) == PIDL_TIMEPROP &&
            $past(slot_idx_q) < $past(drv_q.cool_pct)))
        else $error("time-proportioned cool wrong");
    chk_intsp_sum: assert property ( // [R10]
        CE && BUS_REQ.rd && BUS_REQ.addr == `PIDL_A_INTSP |=>
            RD_DATA == {16'h0000, $past(target_q + corr_q)})
        else $error("internal target read wrong");
    chk_band_hold: assert property ( // [R14]
        CE && !in_band |=> corr_q == $past(corr_q))
        else $error("integration outside band");
    chk_gain_zero: assert property ( // [R14]
        CE && gain_q == 8'h00 |=> corr_q == $past(corr_q))
        else $error("integration with zero band");
    chk_windup_clip: assert property ( // [R15]
        s_repeat |=> corr_q - $past(corr_q) == $past(clip[15:0])
            && $past(clip) <= $past(lim) && $past(clip) >= -$past(lim))
        else $error("integrated step exceeds windup limit");
    chk_ramp_step: assert property ( // [R13]
        s_repeat ##0 (clip == dev) |=>
            corr_q == $past(corr_q) + $past(dev[15:0]))
        else $error("repeat step differs from error");
    chk_no_repeat: assert property ( // [R12]
        CE && !rep_evt |=> corr_q == $past(corr_q))
        else $error("correction changed without repeat");
    chk_deriv_pv: assert property ( // [R16]
        s_step ##0 (pv_q == pvold_q) |-> dpct == 42'h0)
        else $error("derivative without measured change");
    chk_zero_dev: assert property ( // [R2]
        CE && adj == 18'sh0 && dpct == 42'sh0 |=> DRIVE == '0)
        else $error("output without deviation");
endmodule

// File: hw/pidl_defs.svh
// Constants of the three-term control law: register map, resets, timing.
// Assumes a single 125 MHz clock and one includer per compile unit.
// Function
// R1: Deviation is target minus measured value
// R2: Output percent linear in deviation over band
// R3: Band equals span divided by gain
// R4: Span is highest minus lowest target
// R5: Percent maps linearly onto 4-20 mA
// R6: Time-proportioned on fraction equals output percent
// R7: Separate heating and cooling outputs, both sides
// R8: P, I, D computed separately then summed; the code sums only P and D, and I enters through the internal target
// R9: Integral accumulates deviation to cancel error
// R10: Internal target is target plus correction
// R11: Output uses internal target minus measured value
// R12: Correction repeats switch-selected times per minute
// R13: Constant error ramps internal target linearly
// R14: No integration outside the proportional band
// R15: Integrated error clamped to windup percent
// R16: Derivative uses measured value change only
// R17: Repeat switch weighted in hundredths per minute
// R18: Summed output saturated to 0..100 percent
`ifndef PIDL_DEFS_SVH
`define PIDL_DEFS_SVH
`define PIDL_A_TARGET 6'h00
`define PIDL_A_GAIN 6'h04
`define PIDL_A_REPEAT 6'h08
`define PIDL_A_WINDUP 6'h0C
`define PIDL_A_SPLO 6'h10
`define PIDL_A_SPHI 6'h14
`define PIDL_A_DERIV 6'h18
`define PIDL_A_SLOT 6'h1C
`define PIDL_A_MODE 6'h20
`define PIDL_A_STAT 6'h24
`define PIDL_A_INTSP 6'h28
`define PIDL_A_MEAS 6'h2C
`define PIDL_R_GAIN 8'h45
`define PIDL_R_REPEAT 8'h20
`define PIDL_R_WINDUP 8'h64
`define PIDL_R_SPLO 16'hFF9C
`define PIDL_R_SPHI 16'h013B
`define PIDL_R_SLOT 16'h0064
`define PIDL_PCT_FULL 8'h64
`define PIDL_HUND 48'h64
`define PIDL_MA4 16'h0FA0
`define PIDL_UA_PER_PCT 16'h00A0
`define PIDL_MINUTE_NS 64'hD_F847_5800
`define PIDL_CLK_NS 64'h8
`endif

// File: hw/pidl_pkg.sv
// Types shared by the control law core.
// Assumes the register map in pidl_defs.svh.
package pidl_pkg;
    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pidl_req_t;
    typedef struct packed {
        logic [7:0] heat_pct;
        logic [7:0] cool_pct;
    } pidl_drive_t;
    typedef enum logic {PIDL_CURRENT, PIDL_TIMEPROP} pidl_mode_t;
    typedef enum {PIDL_WAIT, PIDL_LATCH} pidl_state_t;
endpackage

// File: test/pidl_plant.sv
// Process sensor and heat/cool actuator model facing the control law.
// Assumes go is a one-cycle request from the bench, synchronous to clk.
`timescale 1ns/100ps
module pidl_plant (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] value,
    input wire logic clr,
    input wire logic heat_on,
    input wire logic cool_on,
    output logic [15:0] meas_value,
    output logic meas_valid,
    output logic [7:0] heat_cnt,
    output logic [7:0] cool_cnt
);
    logic [15:0] last_q;
    // Between samples the sensor bus carries junk, never the old reading
    assign meas_value = meas_valid ? last_q : ~last_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_valid <= 1'b0;
            last_q <= 16'h0000;
            heat_cnt <= 8'h00;
            cool_cnt <= 8'h00;
        end else begin
            meas_valid <= go;
            if (go) begin
                last_q <= value;
            end
            // Actuator on-time counters, one count per clock
            heat_cnt <= clr ? 8'h00 : heat_cnt + 8'(heat_on);
            cool_cnt <= clr ? 8'h00 : cool_cnt + 8'(cool_on);
        end
    end
endmodule

// File: test/testbench.sv
// Self-checking bench for the control law core and its plant model.
// Assumes a shortened minute of 1000 clocks so integration runs quickly.
`timescale 1ns/100ps
`include "pidl_defs.svh"
module testbench;
    import pidl_pkg::*;
    logic clk;
    logic rst;
    logic ce;
    pidl_req_t req;
    logic [31:0] rd_data;
    logic [15:0] meas_value;
    logic meas_valid;
    pidl_drive_t drive;
    logic [15:0] heat_ua;
    logic [15:0] cool_ua;
    logic heat_on;
    logic cool_on;
    logic go;
    logic [15:0] val;
    logic clr;
    logic [7:0] heat_cnt;
    logic [7:0] cool_cnt;
    int mismatches = 0;
    int n_tests = 0;
    pidl_core #(.MINUTE_CYCLES(64'h3E8)) i_pidl_core (.CORE_CLK(clk),
        .RST(rst), .CE(ce), .BUS_REQ(req), .RD_DATA(rd_data),
        .MEAS_VALUE(meas_value), .MEAS_VALID(meas_valid), .DRIVE(drive),
        .HEAT_LOOP_UA(heat_ua), .COOL_LOOP_UA(cool_ua),
        .HEAT_ON(heat_on), .COOL_ON(cool_on));
    pidl_plant i_pidl_plant (.clk(clk), .rst(rst), .go(go), .value(val),
        .clr(clr), .heat_on(heat_on), .cool_on(cool_on),
        .meas_value(meas_value), .meas_valid(meas_valid),
        .heat_cnt(heat_cnt), .cool_cnt(cool_cnt));
    always #4 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One idle cycle after each access keeps the strobe drive single
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string what, input logic [5:0] a,
                         input logic [31:0] exp);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        chk(what, rd_data, exp);
        @(posedge clk);
    endtask
    // Sample to loop output takes three edges after the plant strobe
    task automatic sample(input logic [15:0] v);
        val <= v;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic outs(input logic [7:0] h, input logic [7:0] c);
        chk("heat_pct", 32'(drive.heat_pct), 32'(h));
        chk("cool_pct", 32'(drive.cool_pct), 32'(c));
        chk("heat_ua", 32'(heat_ua), 32'(`PIDL_MA4 + `PIDL_UA_PER_PCT * 16'(h)));
        chk("cool_ua", 32'(cool_ua), 32'(`PIDL_MA4 + `PIDL_UA_PER_PCT * 16'(c)));
    endtask
    // Two repeats per minute run for one shortened minute
    task automatic ramp(input logic [15:0] m, input logic [31:0] exp);
        sample(m);
        wr(`PIDL_A_REPEAT, 32'hC8);
        repeat (999) @(posedge clk);
        wr(`PIDL_A_REPEAT, 32'h0);
        rdchk("int_target", `PIDL_A_INTSP, exp);
    endtask
    task automatic t_reset();
        #1;
        chk("loop_rst", 32'(heat_ua), 32'(`PIDL_MA4));
        rdchk("gain", `PIDL_A_GAIN, 32'(`PIDL_R_GAIN));
        rdchk("windup", `PIDL_A_WINDUP, 32'(`PIDL_R_WINDUP));
        rdchk("span_hi", `PIDL_A_SPHI, 32'(`PIDL_R_SPHI));
        rdchk("unmapped", 6'h30, 32'h0);
        #1;
        chk("rd_idle", rd_data, 32'h0);
    endtask
    task automatic t_prop();
        wr(`PIDL_A_REPEAT, 32'h0);
        wr(`PIDL_A_SPLO, 32'h0);
        wr(`PIDL_A_SPHI, 32'h64);
        wr(`PIDL_A_GAIN, 32'hA);
        wr(`PIDL_A_TARGET, 32'h32);
        sample(16'h002D);
        outs(8'h32, 8'h00);
        rdchk("status", `PIDL_A_STAT, 32'h0000_3200);
        sample(16'h0023);
        outs(8'h64, 8'h00);
        sample(16'h0035);
        outs(8'h00, 8'h1E);
        wr(`PIDL_A_GAIN, 32'h14);
        sample(16'h002F);
        outs(8'h3C, 8'h00);
        wr(`PIDL_A_SPHI, 32'hC8);
        sample(16'h002F);
        outs(8'h1E, 8'h00);
        wr(`PIDL_A_SPHI, 32'h64);
        wr(`PIDL_A_GAIN, 32'hA);
    endtask
    task automatic t_deriv();
        wr(`PIDL_A_DERIV, 32'h2);
        sample(16'h002D);
        sample(16'h002D);
        outs(8'h32, 8'h00);
        sample(16'h002C);
        outs(8'h3E, 8'h00);
        wr(`PIDL_A_TARGET, 32'h33);
        sample(16'h002C);
        outs(8'h46, 8'h00);
        wr(`PIDL_A_DERIV, 32'h0);
        wr(`PIDL_A_TARGET, 32'h32);
    endtask
    // One full 100-slot period of actuator on-time
    task automatic duty(input logic [7:0] h, input logic [7:0] c);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk("heat_on_cycles", 32'(heat_cnt), 32'(h));
        chk("cool_on_cycles", 32'(cool_cnt), 32'(c));
    endtask
    task automatic t_tprop();
        wr(`PIDL_A_MODE, 32'h1);
        wr(`PIDL_A_SLOT, 32'h1);
        sample(16'h002F);
        duty(8'h1E, 8'h00);
        sample(16'h0035);
        duty(8'h00, 8'h1E);
        wr(`PIDL_A_MODE, 32'h0);
        duty(8'h00, 8'h00);
    endtask
    // Enable low must freeze the loop and ignore bus and sensor
    task automatic t_hold();
        ce <= 1'b0;
        wr(`PIDL_A_TARGET, 32'h64);
        sample(16'h0000);
        ce <= 1'b1;
        outs(8'h3C, 8'h00);
        rdchk("held_target", `PIDL_A_TARGET, 32'h32);
    endtask
    task automatic t_integ();
        rdchk("int_target", `PIDL_A_INTSP, 32'h32);
        ramp(16'h0030, 32'h36);
        sample(16'h0030);
        outs(8'h3C, 8'h00);
        t_hold();
        wr(`PIDL_A_WINDUP, 32'hA);
        ramp(16'h002D, 32'h38);
        ramp(16'h001E, 32'h38);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole run is about 3500 clocks; the limit leaves wide margin
    initial begin
        #400000;
        mismatches++;
        end_of_test();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        go = 1'b0;
        val = 16'h0000;
        clr = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_prop();
        t_deriv();
        t_tprop();
        t_integ();
        end_of_test();
    end
endmodule
